// [core/csfr_consts.svh]
// Offsets, field positions, reset values and stack limits of the core special function registers
`ifndef CSFR_CONSTS_SVH
`define CSFR_CONSTS_SVH
`define CSFR_ADDR_STACK_LOW 8'h81
`define CSFR_ADDR_DP_LOW 8'h82
`define CSFR_ADDR_DP_HIGH 8'h83
`define CSFR_ADDR_DP_PAGE 8'h84
`define CSFR_ADDR_POWER_CTRL 8'h87
`define CSFR_ADDR_STACK_EXT 8'hb7
`define CSFR_ADDR_STATUS 8'hd0
`define CSFR_ADDR_MATH 8'he0
`define CSFR_ADDR_HELPER 8'hf0
`define CSFR_ADDR_CORE_CFG 8'haf
`define CSFR_ADDR_CAL_OFS 8'hf1
`define CSFR_ADDR_CAL_GAIN 8'hf3
`define CSFR_ADDR_PORT1 8'h90
`define CSFR_RST_STACK_LOW 8'h07
`define CSFR_RST_STACK_EXT 8'h00
`define CSFR_RST_POWER_CTRL 8'h00
`define CSFR_RST_STATUS 8'h00
`define CSFR_RST_PORT1 8'hff
`define CSFR_STACK_EXT_MASK 8'h07
`define CSFR_CFG_STACK_EXT_BIT 7
`define CSFR_PC_RATE_DOUBLER 7
`define CSFR_PC_SERIAL_WAKE 6
`define CSFR_PC_EXTINT_WAKE 5
`define CSFR_PC_LATCH_OFF 4
`define CSFR_PC_POWERDOWN 1
`define CSFR_PC_LIGHT_SLEEP 0
`define CSFR_PSW_BANK_HIGH 4
`define CSFR_PSW_BANK_LOW 3
`define CSFR_PSW_PARITY 0
`define CSFR_XRAM_STACK_BASE 11'h100
`endif

// [core/csfr_pkg.sv]
// Types shared by the core special function register block
package csfr_pkg;
    typedef enum logic [1:0] {csfr_op_none, csfr_op_push, csfr_op_pop} csfr_stack_op_t;
    typedef struct packed {
        logic [7:0] math_q;
        logic [7:0] helper_q;
        logic [7:0] stack_low_q;
        logic [2:0] stack_ext_q;
        logic [7:0] dp_page_q;
        logic [7:0] dp_high_q;
        logic [7:0] dp_low_q;
        logic [7:0] status_q;
        logic [7:0] power_q;
        logic [7:0] core_cfg_q;
        logic [7:0] port1_q;
        logic [7:0] port1_en_q;
        logic [15:0] cal_ofs_q;
        logic [15:0] cal_gain_q;
        logic cal_loaded_q;
        logic [7:0] rdata_q;
        logic [10:0] stack_addr_q;
        logic stack_wr_q;
        logic [7:0] stack_wdata_q;
        logic idle_q;
        logic powerdown_q;
        logic wake_q;
    } csfr_state_t;
endpackage

// [core/csfr_core_regs.sv]
// Core special function registers: math, helper, stack, data pointer, status and power control
//
// What this block does
// - Push increments pointer before writing data.
// - Reset puts stack pointer at 07H.
// - Extension low three bits form address top.
// - Pointer increment carries high into page.
// - Helper takes multiply/divide result, else scratch.
// - Status bits 4:3 select bank binary.
// - Bit 7 doubles baud; bits 3,2 flags.
// - Bit 6 lets serial interrupt end powerdown.
// - Bit 5 lets external interrupt end powerdown.
// - Unoccupied addresses: no storage, writes ignored.
// - Bit access only at 0H/8H addresses.
// - Port 1 digital only after writing 0.
// - Calibration loaded from factory at power-up.
// - Stack wraps FFH, or continues to 0100H.
// - Stack pointer low byte at 81H.
`timescale 1ns/100ps
`include "csfr_consts.svh"
module csfr_core_regs (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Special function byte access
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // Bit access
    input wire logic bit_wr,
    input wire logic [2:0] bit_sel,
    input wire logic bit_val,
    // Execution unit updates
    input wire logic [7:0] alu_math,
    input wire logic alu_math_we,
    input wire logic [7:0] alu_helper,
    input wire logic muldiv_we,
    input wire logic [2:0] alu_flags,
    input wire logic alu_flags_we,
    input wire logic dp_inc,
    input wire csfr_pkg::csfr_stack_op_t stack_op,
    input wire logic [7:0] stack_push_data,
    // Factory calibration source
    input wire logic [15:0] factory_cal_ofs,
    input wire logic [15:0] factory_cal_gain,
    // Wake sources
    input wire logic serial_irq,
    input wire logic extint0_irq,
    // Status out
    output logic [10:0] stack_addr,
    output logic stack_wr,
    output logic [7:0] stack_wdata,
    output logic [1:0] bank_sel,
    output logic [7:0] helper_operand,
    output logic [23:0] data_pointer,
    output logic uart_rate_doubler,
    output logic latch_strobe_disable,
    output logic idle_mode,
    output logic powerdown_mode,
    output logic wake_event,
    output logic [7:0] port1_digital_en,
    output logic [15:0] cal_ofs,
    output logic [15:0] cal_gain
);
    import csfr_pkg::*;

    csfr_state_t s_q;
    csfr_state_t s_d;

    // ==============================================
    // Next state
    always_comb begin
        logic [10:0] sp_now;
        logic [10:0] sp_next;
        logic [16:0] dp_sum;
        logic [7:0] bit_reg;
        logic [7:0] bit_new;
        logic hit;
        sp_now = 11'h000;
        sp_next = 11'h000;
        dp_sum = 17'h00000;
        bit_reg = 8'h00;
        bit_new = 8'h00;
        hit = 1'b0;
        s_d = s_q;
        s_d.stack_wr_q = 1'b0;
        s_d.wake_q = 1'b0;

        if (!s_q.cal_loaded_q) begin
            s_d.cal_ofs_q = factory_cal_ofs;
            s_d.cal_gain_q = factory_cal_gain;
            s_d.cal_loaded_q = 1'b1;
        end

        if (bit_wr && (sfr_addr[2:0] == 3'h0)) begin
            if (sfr_addr == `CSFR_ADDR_STATUS) begin
                bit_reg = s_q.status_q;
                hit = 1'b1;
            end else if (sfr_addr == `CSFR_ADDR_MATH) begin
                bit_reg = s_q.math_q;
                hit = 1'b1;
            end else if (sfr_addr == `CSFR_ADDR_HELPER) begin
                bit_reg = s_q.helper_q;
                hit = 1'b1;
            end else if (sfr_addr == `CSFR_ADDR_PORT1) begin
                bit_reg = s_q.port1_q;
                hit = 1'b1;
            end
            bit_new = bit_reg;
            bit_new[bit_sel] = bit_val;
            if (hit) begin
                if (sfr_addr == `CSFR_ADDR_STATUS) begin
                    s_d.status_q = bit_new;
                end else if (sfr_addr == `CSFR_ADDR_MATH) begin
                    s_d.math_q = bit_new;
                end else if (sfr_addr == `CSFR_ADDR_HELPER) begin
                    s_d.helper_q = bit_new;
                end else begin
                    s_d.port1_q = bit_new;
                end
            end
        end

        if (sfr_wr) begin
            if (sfr_addr == `CSFR_ADDR_STACK_LOW) begin
                s_d.stack_low_q = sfr_wdata;
            end else if (sfr_addr == `CSFR_ADDR_STACK_EXT) begin
                s_d.stack_ext_q = sfr_wdata[2:0];
            end else if (sfr_addr == `CSFR_ADDR_DP_LOW) begin
                s_d.dp_low_q = sfr_wdata;
            end else if (sfr_addr == `CSFR_ADDR_DP_HIGH) begin
                s_d.dp_high_q = sfr_wdata;
            end else if (sfr_addr == `CSFR_ADDR_DP_PAGE) begin
                s_d.dp_page_q = sfr_wdata;
            end else if (sfr_addr == `CSFR_ADDR_POWER_CTRL) begin
                s_d.power_q = sfr_wdata;
            end else if (sfr_addr == `CSFR_ADDR_STATUS) begin
                s_d.status_q = sfr_wdata;
            end else if (sfr_addr == `CSFR_ADDR_MATH) begin
                s_d.math_q = sfr_wdata;
            end else if (sfr_addr == `CSFR_ADDR_HELPER) begin
                s_d.helper_q = sfr_wdata;
            end else if (sfr_addr == `CSFR_ADDR_CORE_CFG) begin
                s_d.core_cfg_q = sfr_wdata;
            end else if (sfr_addr == `CSFR_ADDR_PORT1) begin
                s_d.port1_q = sfr_wdata;
            end
        end

        // Execution results win over software writes
        if (alu_math_we) begin
            s_d.math_q = alu_math;
        end
        if (muldiv_we) begin
            s_d.helper_q = alu_helper;
        end
        if (alu_flags_we) begin
            s_d.status_q[7] = alu_flags[2];
            s_d.status_q[6] = alu_flags[1];
            s_d.status_q[2] = alu_flags[0];
        end

        if (dp_inc) begin
            dp_sum = {1'b0, s_q.dp_high_q, s_q.dp_low_q} + 17'h00001;
            s_d.dp_low_q = dp_sum[7:0];
            s_d.dp_high_q = dp_sum[15:8];
            s_d.dp_page_q = s_q.dp_page_q + {7'h00, dp_sum[16]};
        end

        sp_now = {s_q.stack_ext_q, s_q.stack_low_q};
        case (stack_op)
            csfr_op_push: begin
                if (s_q.core_cfg_q[`CSFR_CFG_STACK_EXT_BIT]) begin
                    sp_next = sp_now + 11'h001;
                end else begin
                    sp_next = {s_q.stack_ext_q, s_q.stack_low_q + 8'h01};
                end
                s_d.stack_low_q = sp_next[7:0];
                s_d.stack_ext_q = sp_next[10:8];
                s_d.stack_addr_q = sp_next;
                s_d.stack_wr_q = 1'b1;
                s_d.stack_wdata_q = stack_push_data;
            end
            csfr_op_pop: begin
                if (s_q.core_cfg_q[`CSFR_CFG_STACK_EXT_BIT]) begin
                    sp_next = sp_now - 11'h001;
                end else begin
                    sp_next = {s_q.stack_ext_q, s_q.stack_low_q - 8'h01};
                end
                s_d.stack_addr_q = sp_now;
                s_d.stack_low_q = sp_next[7:0];
                s_d.stack_ext_q = sp_next[10:8];
            end
            default: begin
                s_d.stack_addr_q = sp_now;
            end
        endcase

        s_d.status_q[`CSFR_PSW_PARITY] = ^s_d.math_q;
        s_d.port1_en_q = ~s_d.port1_q;

        s_d.idle_q = s_d.power_q[`CSFR_PC_LIGHT_SLEEP];
        s_d.powerdown_q = s_d.power_q[`CSFR_PC_POWERDOWN];
        if (s_q.powerdown_q &&
            ((serial_irq && s_q.power_q[`CSFR_PC_SERIAL_WAKE]) ||
             (extint0_irq && s_q.power_q[`CSFR_PC_EXTINT_WAKE]))) begin
            s_d.power_q[`CSFR_PC_POWERDOWN] = 1'b0;
            s_d.powerdown_q = 1'b0;
            s_d.wake_q = 1'b1;
        end
        // Any interrupt ends idle
        if (s_q.idle_q && (serial_irq || extint0_irq)) begin
            s_d.power_q[`CSFR_PC_LIGHT_SLEEP] = 1'b0;
            s_d.idle_q = 1'b0;
        end

        // Registered read; unmapped reads give zero
        s_d.rdata_q = 8'h00;
        if (sfr_rd) begin
            if (sfr_addr == `CSFR_ADDR_STACK_LOW) begin
                s_d.rdata_q = s_q.stack_low_q;
            end else if (sfr_addr == `CSFR_ADDR_STACK_EXT) begin
                s_d.rdata_q = {5'h00, s_q.stack_ext_q};
            end else if (sfr_addr == `CSFR_ADDR_DP_LOW) begin
                s_d.rdata_q = s_q.dp_low_q;
            end else if (sfr_addr == `CSFR_ADDR_DP_HIGH) begin
                s_d.rdata_q = s_q.dp_high_q;
            end else if (sfr_addr == `CSFR_ADDR_DP_PAGE) begin
                s_d.rdata_q = s_q.dp_page_q;
            end else if (sfr_addr == `CSFR_ADDR_POWER_CTRL) begin
                s_d.rdata_q = s_q.power_q;
            end else if (sfr_addr == `CSFR_ADDR_STATUS) begin
                s_d.rdata_q = s_q.status_q;
            end else if (sfr_addr == `CSFR_ADDR_MATH) begin
                s_d.rdata_q = s_q.math_q;
            end else if (sfr_addr == `CSFR_ADDR_HELPER) begin
                s_d.rdata_q = s_q.helper_q;
            end else if (sfr_addr == `CSFR_ADDR_CORE_CFG) begin
                s_d.rdata_q = s_q.core_cfg_q;
            end else if (sfr_addr == `CSFR_ADDR_PORT1) begin
                s_d.rdata_q = s_q.port1_q;
            end else if (sfr_addr == `CSFR_ADDR_CAL_OFS) begin
                s_d.rdata_q = s_q.cal_ofs_q[7:0];
            end else if (sfr_addr == `CSFR_ADDR_CAL_GAIN) begin
                s_d.rdata_q = s_q.cal_gain_q[7:0];
            end
        end
    end

    // ==============================================
    // State register
    always_ff @(posedge clk) begin
        if (srst) begin
            s_q <= '0;
            s_q.stack_low_q <= `CSFR_RST_STACK_LOW;
            s_q.stack_ext_q <= 3'h0;
            s_q.status_q <= `CSFR_RST_STATUS;
            s_q.power_q <= `CSFR_RST_POWER_CTRL;
            s_q.port1_q <= `CSFR_RST_PORT1;
            s_q.port1_en_q <= ~`CSFR_RST_PORT1;
            s_q.stack_addr_q <= {3'h0, `CSFR_RST_STACK_LOW};
        end else begin
            s_q <= s_d;
        end
    end

    // ==============================================
    // Outputs, all straight from flip-flops
    assign sfr_rdata = s_q.rdata_q;
    assign stack_addr = s_q.stack_addr_q;
    assign stack_wr = s_q.stack_wr_q;
    assign stack_wdata = s_q.stack_wdata_q;
    assign bank_sel = {s_q.status_q[`CSFR_PSW_BANK_HIGH], s_q.status_q[`CSFR_PSW_BANK_LOW]};
    assign helper_operand = s_q.helper_q;
    assign data_pointer = {s_q.dp_page_q, s_q.dp_high_q, s_q.dp_low_q};
    assign uart_rate_doubler = s_q.power_q[`CSFR_PC_RATE_DOUBLER];
    assign latch_strobe_disable = s_q.power_q[`CSFR_PC_LATCH_OFF];
    assign idle_mode = s_q.idle_q;
    assign powerdown_mode = s_q.powerdown_q;
    assign wake_event = s_q.wake_q;
    // digital only where bit is 0
    assign port1_digital_en = s_q.port1_en_q;
    assign cal_ofs = s_q.cal_ofs_q;
    assign cal_gain = s_q.cal_gain_q;
endmodule

// [sim/csfr_regs_monitor.sv]
// Port-level assertions for the core register block
`timescale 1ns/100ps
module csfr_regs_monitor
    import csfr_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Watched ports
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic dp_inc,
    input wire csfr_pkg::csfr_stack_op_t stack_op,
    input wire logic [7:0] stack_push_data,
    input wire logic serial_irq,
    input wire logic extint0_irq,
    input wire logic [10:0] stack_addr,
    input wire logic stack_wr,
    input wire logic [7:0] stack_wdata,
    input wire logic [1:0] bank_sel,
    input wire logic [23:0] data_pointer,
    input wire logic powerdown_mode
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // ==========
    // Properties
    property p_push_data; stack_op == csfr_op_push |=> stack_wr && stack_wdata == $past(stack_push_data); endproperty
    a_push_data: assert property (p_push_data) else $error("push data not written");
    property p_push_inc; stack_op == csfr_op_push ##1 stack_op == csfr_op_push && !sfr_wr
        |=> stack_addr[7:0] == $past(stack_addr[7:0]) + 8'h01; endproperty
    a_push_inc: assert property (p_push_inc) else $error("pointer not advanced");
    property p_rst_ptr; $fell(srst) |-> stack_addr == 11'h007; endproperty
    a_rst_ptr: assert property (p_rst_ptr) else $error("stack pointer reset wrong");
    property p_bank; sfr_wr && sfr_addr == 8'hd0 |=> bank_sel == $past(sfr_wdata[4:3]); endproperty
    a_bank: assert property (p_bank) else $error("bank select wrong");
    property p_unmapped; sfr_rd && sfr_addr == 8'h85 |=> sfr_rdata == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_dp_carry; dp_inc && !sfr_wr && data_pointer[15:0] == 16'hffff
        |=> data_pointer == {$past(data_pointer[23:16]) + 8'h01, 16'h0000}; endproperty
    a_dp_carry: assert property (p_dp_carry) else $error("page carry lost");
    // Quiet cycles keep a wake from undoing the request
    property p_pd_enter; sfr_wr && sfr_addr == 8'h87 && sfr_wdata[1] && !serial_irq && !extint0_irq
        ##1 !serial_irq && !extint0_irq |=> powerdown_mode; endproperty
    a_pd_enter: assert property (p_pd_enter) else $error("powerdown not entered");
    property p_pd_hold; (!sfr_wr && !serial_irq && !extint0_irq)[*2] ##0 powerdown_mode |=> powerdown_mode;
    endproperty
    a_pd_hold: assert property (p_pd_hold) else $error("powerdown left without cause");
endmodule
bind csfr_core_regs csfr_regs_monitor i_mon (.clk, .srst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
    .dp_inc, .stack_op, .stack_push_data, .serial_irq, .extint0_irq, .stack_addr, .stack_wr, .stack_wdata,
    .bank_sel, .data_pointer, .powerdown_mode);

// [sim/csfr_exec_model.sv]
// Behavioural execution core feeding the register block
`timescale 1ns/100ps
module csfr_exec_model
    import csfr_pkg::*;
(
    // Clock
    input wire logic clk,
    // Core updates
    output csfr_pkg::csfr_stack_op_t stack_op = csfr_op_none,
    output logic [7:0] stack_push_data = 8'h00,
    output logic dp_inc = 1'b0,
    output logic [7:0] alu_math = 8'h00,
    output logic alu_math_we = 1'b0,
    output logic [7:0] alu_helper = 8'h00,
    output logic muldiv_we = 1'b0
);
    // ==========
    // Operations
    task automatic push(input logic [7:0] d, input int n);
        @(posedge clk);
        for (int i = 0; i < n; i++) begin
            stack_op <= csfr_op_push;
            stack_push_data <= d + 8'(i);
            @(posedge clk);
        end
        stack_op <= csfr_op_none;
        // Stale data would hide a missed sample
        stack_push_data <= ~stack_push_data;
        #1;
    endtask
    task automatic pop();
        @(posedge clk);
        stack_op <= csfr_op_pop;
        @(posedge clk);
        stack_op <= csfr_op_none;
        #1;
    endtask
    task automatic inc_dp();
        @(posedge clk);
        dp_inc <= 1'b1;
        @(posedge clk);
        dp_inc <= 1'b0;
        #1;
    endtask
    task automatic muldiv(input logic [7:0] a, input logic [7:0] b);
        @(posedge clk);
        alu_math <= a;
        alu_helper <= b;
        alu_math_we <= 1'b1;
        muldiv_we <= 1'b1;
        @(posedge clk);
        alu_math_we <= 1'b0;
        muldiv_we <= 1'b0;
    endtask
endmodule

// [sim/test_csfr_core_regs.sv]
// Self-checking bench for the core register block
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_csfr_core_regs;
    import csfr_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic bit_wr = 1'b0;
    logic [2:0] bit_sel = 3'h0;
    logic bit_val = 1'b0;
    logic serial_irq = 1'b0;
    logic extint0_irq = 1'b0;
    logic [7:0] sfr_rdata, alu_math, alu_helper, stack_push_data, stack_wdata, helper_operand, port1_digital_en, q;
    logic alu_math_we, muldiv_we, dp_inc, stack_wr, uart_rate_doubler, latch_strobe_disable, idle_mode, s;
    logic powerdown_mode, wake_event;
    logic [10:0] stack_addr;
    logic [1:0] bank_sel;
    logic [23:0] data_pointer;
    logic [15:0] cal_ofs, cal_gain;
    csfr_stack_op_t stack_op;
    int bad_count = 0;
    int n_checks = 0;
    csfr_core_regs i_dut (.clk, .srst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .bit_wr, .bit_sel,
        .bit_val, .alu_math, .alu_math_we, .alu_helper, .muldiv_we, .alu_flags(3'h0), .alu_flags_we(1'b0),
        .dp_inc, .stack_op, .stack_push_data, .factory_cal_ofs(16'h1357), .factory_cal_gain(16'h2468),
        .serial_irq, .extint0_irq, .stack_addr, .stack_wr, .stack_wdata, .bank_sel, .helper_operand,
        .data_pointer, .uart_rate_doubler, .latch_strobe_disable, .idle_mode, .powerdown_mode, .wake_event,
        .port1_digital_en, .cal_ofs, .cal_gain);
    csfr_exec_model i_exec (.clk, .stack_op, .stack_push_data, .dp_inc, .alu_math, .alu_math_we, .alu_helper,
        .muldiv_we);
    always #2 clk = ~clk;
    // ==========
    // Bus cycles
    // mapped or spare only
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic b = 1'b0);
        @(posedge clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= !b;
        bit_wr <= b;
        bit_sel <= d[2:0];
        bit_val <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
        bit_wr <= 1'b0;
        sfr_wdata <= ~d;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk);
        sfr_rd <= 1'b0;
        #1 v = sfr_rdata;
    endtask
    // Wake pulse is one cycle wide, so look every cycle
    task automatic irq(input logic ext, output logic seen);
        @(posedge clk);
        serial_irq <= !ext;
        extint0_irq <= ext;
        @(posedge clk);
        serial_irq <= 1'b0;
        extint0_irq <= 1'b0;
        seen = 1'b0;
        for (int i = 0; i < 4 && !seen; i++) begin
            #1 seen = wake_event;
            @(posedge clk);
        end
    endtask
    // ==========
    // Scenarios
    task automatic t_reset();
        rd(8'h81, q);
        `CHK(q, 8'h07)
        `CHK(stack_addr, 11'h007)
        `CHK(cal_ofs, 16'h1357)
        `CHK(cal_gain, 16'h2468)
        `CHK(port1_digital_en, 8'h00)
        wr(8'h90, 8'hfe);
        `CHK(port1_digital_en, 8'h01)
        wr(8'h85, 8'hff);
        rd(8'h85, q);
        `CHK(q, 8'h00)
    endtask
    task automatic t_stack();
        wr(8'hb7, 8'hff);
        rd(8'hb7, q);
        `CHK(q, 8'h07)
        wr(8'h81, 8'h10);
        i_exec.push(8'h55, 2);
        `CHK(stack_wr, 1'b1)
        `CHK(stack_wdata, 8'h56)
        `CHK(stack_addr, 11'h712)
        for (int c = 0; c < 2; c++) begin
            wr(8'hb7, 8'h00);
            wr(8'h81, 8'hff);
            wr(8'haf, c ? 8'h80 : 8'h00);
            i_exec.push(8'ha0, 1);
            `CHK(stack_addr, c ? 11'h100 : 11'h000)
        end
        // Pop from 100 shows the old slot, then steps back below the extension
        i_exec.pop();
        `CHK(stack_addr, 11'h100)
        rd(8'hb7, q);
        `CHK(q, 8'h00)
        rd(8'h81, q);
        `CHK(q, 8'hff)
        wr(8'h84, 8'h12);
        wr(8'h83, 8'hff);
        wr(8'h82, 8'hff);
        i_exec.inc_dp();
        `CHK(data_pointer, 24'h130000)
    endtask
    task automatic t_math();
        i_exec.muldiv(8'h2a, 8'hc3);
        rd(8'hf0, q);
        `CHK(q, 8'hc3)
        `CHK(helper_operand, 8'hc3)
        wr(8'hf0, 8'h5a);
        rd(8'hf0, q);
        `CHK(q, 8'h5a)
        for (int b = 0; b < 4; b++) begin
            wr(8'hd0, 8'(b << 3));
            `CHK(bank_sel, 2'(b))
            rd(8'hd0, q);
            // Accumulator holds three ones
            `CHK(q, 8'(b << 3) | 8'h01)
        end
        wr(8'hd0, 8'h05, 1'b1);
        rd(8'hd0, q);
        `CHK(q, 8'h39)
    endtask
    task automatic t_power();
        wr(8'h87, 8'h02, 1'b1);
        rd(8'h87, q);
        `CHK(q, 8'h00)
        wr(8'h87, 8'hac);
        rd(8'h87, q);
        `CHK(q, 8'hac)
        `CHK(uart_rate_doubler, 1'b1)
        wr(8'h87, 8'hb2);
        @(posedge clk);
        #1;
        `CHK(powerdown_mode, 1'b1)
        `CHK(latch_strobe_disable, 1'b1)
        irq(1'b0, s);
        `CHK(s, 1'b0)
        `CHK(powerdown_mode, 1'b1)
        irq(1'b1, s);
        `CHK(s, 1'b1)
        `CHK(powerdown_mode, 1'b0)
        wr(8'h87, 8'h42);
        irq(1'b0, s);
        `CHK(s, 1'b1)
        wr(8'h87, 8'h01);
        @(posedge clk);
        #1;
        `CHK(idle_mode, 1'b1)
    endtask
    task automatic tally_and_finish();
        if (bad_count == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_stack();
        t_math();
        t_power();
        tally_and_finish();
    end
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        tally_and_finish();
    end
endmodule
